// ===== hw/sbc_regs.svh
// Purpose: shared constants of the serial code converter
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// width of one bcd digit
`define SBC_DIG_W 4
// digit value from which doubling must be corrected
`define SBC_DIG_HALF 4'h5
// decimal base taken off a corrected doubled digit
`define SBC_DIG_TEN 5'h0A
// carry position of a doubled digit
`define SBC_CARRY_BIT 5'h10
// weight of a bit crossing into the digit below
`define SBC_FIVE 5'h05
// width of the bit counters
`define SBC_CNT_W 8
// counter step
`define SBC_CNT_ONE 8'h01
// fill levels of the two-entry buffer
`define SBC_BUF_FULL 2'h2
`define SBC_BUF_ONE 2'h1

`endif

// ===== hw/sbc_pkg.sv
// Purpose: types of the serial code converter
// Assumes: used with full package scope, never imported
// Notes: state codes written out
package sbc_pkg;

   // binary-to-bcd sequencer
   typedef enum logic [1:0] {
      SBC_B_IDLE = 2'h0,
      SBC_B_SHIFT = 2'h1,
      SBC_B_PUSH = 2'h2
   } sbc_bstate_t;

   // bcd-to-binary sequencer
   typedef enum logic {
      SBC_D_IDLE = 1'h0,
      SBC_D_RUN = 1'h1
   } sbc_dstate_t;

endpackage

// ===== hw/sbc_skid2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: all outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.svh"

module sbc_skid2 #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // filling side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   // draining side
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data
);

   if (W < 1) begin : g_chk
      $error("sbc_skid2: W must be at least 1");
   end

   logic [W-1:0] spare;
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic push;
   logic pop;

   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_comb begin
      next_cnt = cnt;
      if (push && !pop) begin
         next_cnt = cnt + `SBC_BUF_ONE;
      end else if (pop && !push) begin
         next_cnt = cnt - `SBC_BUF_ONE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt <= '0;
         o_valid <= 1'b0;
         o_ready <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_valid <= (next_cnt != '0);
         o_ready <= (next_cnt != `SBC_BUF_FULL);
      end
   end

   // head word and the word waiting behind it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_data <= '0;
         spare <= '0;
      end else if (pop) begin
         if (cnt == `SBC_BUF_FULL) begin
            o_data <= spare;
            if (push) begin
               spare <= i_data;
            end
         end else if (push) begin
            o_data <= i_data;
         end
      end else if (push) begin
         if (cnt == '0) begin
            o_data <= i_data;
         end else begin
            spare <= i_data;
         end
      end
   end

endmodule

`default_nettype wire

// ===== hw/sbc_conv.sv
// Purpose: serial binary to parallel bcd and parallel bcd to serial binary
// Assumes: surrounding logic on i_clk drives all inputs; synchronous reset
// Notes: bcd results pass a two-entry buffer so a stalled reader loses none
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs.svh"

module sbc_conv #(
   parameter int DIGITS = 5,
   parameter int BIN_W = 16,
   parameter int DEC_BITS = 17
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // serial binary in
   input wire logic i_bin_bit,
   input wire logic i_bin_valid,
   input wire logic i_start_n,
   output logic o_bin_ready,
   // parallel bcd result
   output logic [DIGITS*`SBC_DIG_W-1:0] o_bcd,
   output logic o_bcd_valid,
   input wire logic i_bcd_ready,
   // parallel bcd in
   input wire logic [DIGITS*`SBC_DIG_W-1:0] i_bcd_load,
   input wire logic i_parallel_load_n,
   // serial binary out
   output logic o_ser_bit,
   output logic o_ser_valid,
   output logic o_conv_done,
   output logic o_d2b_busy
);

   localparam int BW = DIGITS * `SBC_DIG_W;
   localparam int CW = `SBC_CNT_W;
   localparam logic [CW-1:0] B_LAST = CW'(BIN_W - 1);
   localparam logic [CW-1:0] D_LAST = CW'(DEC_BITS - 1);

   if (DIGITS < 1 || DIGITS > 9 || BIN_W < 2 || DEC_BITS < 2
       || BIN_W > 255 || DEC_BITS > 255
       || 2.0 ** BIN_W > 10.0 ** DIGITS || 10.0 ** DIGITS > 2.0 ** DEC_BITS) begin : g_chk
      $error("sbc_conv: DIGITS, BIN_W or DEC_BITS out of range");
   end

   // doubling of one digit with carry in; returns carry out and new digit
   function automatic logic [4:0] sbc_dbl(input logic [3:0] d, input logic cin);
      logic [4:0] t;
      t = {d, cin};
      if (d >= `SBC_DIG_HALF) begin
         t = (t - `SBC_DIG_TEN) | `SBC_CARRY_BIT;
      end
      return t;
   endfunction

   // ---------------- binary to bcd ----------------
   sbc_pkg::sbc_bstate_t bstate;
   sbc_pkg::sbc_bstate_t next_bstate;
   logic [BW-1:0] bcd_sh;
   logic [BW-1:0] next_bcd;
   logic [DIGITS:0] bc;
   logic [CW-1:0] b_cnt;
   logic b_take;
   logic buf_ready;

   assign b_take = i_bin_valid && o_bin_ready;
   assign bc[0] = i_bin_bit;

   for (genvar g = 0; g < DIGITS; g++) begin : g_dbl
      assign {bc[g+1], next_bcd[g*4 +: 4]} = sbc_dbl(bcd_sh[g*4 +: 4], bc[g]);
   end

   always_comb begin
      next_bstate = bstate;
      if (b_take && !i_start_n) begin
         next_bstate = sbc_sh_next(1'b1);
      end else begin
         unique case (bstate)
            sbc_pkg::SBC_B_IDLE: next_bstate = sbc_pkg::SBC_B_IDLE;
            sbc_pkg::SBC_B_SHIFT: begin
               if (b_take && b_cnt == B_LAST) begin
                  next_bstate = sbc_pkg::SBC_B_PUSH;
               end
            end
            sbc_pkg::SBC_B_PUSH: begin
               if (buf_ready) begin
                  next_bstate = sbc_pkg::SBC_B_IDLE;
               end
            end
            default: next_bstate = sbc_pkg::SBC_B_IDLE;
         endcase
      end
   end

   // state after a start: a one-bit word is complete at once
   function automatic sbc_pkg::sbc_bstate_t sbc_sh_next(input logic dummy);
      sbc_pkg::sbc_bstate_t s;
      s = (B_LAST == '0) ? sbc_pkg::SBC_B_PUSH : sbc_pkg::SBC_B_SHIFT;
      return dummy ? s : sbc_pkg::SBC_B_IDLE;
   endfunction

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bstate <= sbc_pkg::SBC_B_IDLE;
         o_bin_ready <= 1'b0;
      end else begin
         bstate <= next_bstate;
         o_bin_ready <= (next_bstate != sbc_pkg::SBC_B_PUSH);
      end
   end

   // shift register and bit count
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bcd_sh <= '0;
         b_cnt <= '0;
      end else if (b_take && !i_start_n) begin
         bcd_sh <= {{(BW-1){1'b0}}, i_bin_bit};
         b_cnt <= `SBC_CNT_ONE;
      end else if (b_take && bstate == sbc_pkg::SBC_B_SHIFT) begin
         bcd_sh <= next_bcd;
         b_cnt <= b_cnt + `SBC_CNT_ONE;
      end
   end

   sbc_skid2 #(
      .W(BW)
   ) u_buf (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(bstate == sbc_pkg::SBC_B_PUSH),
      .o_ready(buf_ready),
      .i_data(bcd_sh),
      .o_valid(o_bcd_valid),
      .i_ready(i_bcd_ready),
      .o_data(o_bcd)
   );

   // ---------------- bcd to binary ----------------
   sbc_pkg::sbc_dstate_t dstate;
   logic [DIGITS*3-1:0] q;
   logic [DIGITS*3-1:0] next_q;
   logic [DIGITS-1:0] c0;
   logic [DIGITS-1:0] c2;
   logic [DIGITS-1:0] next_c0;
   logic [DIGITS-1:0] next_c2;
   logic [DIGITS-1:0] load_msb;
   logic [DIGITS:0] hb;
   logic [CW-1:0] d_cnt;

   assign hb[DIGITS] = 1'b0;

   for (genvar g = 0; g < DIGITS; g++) begin : g_half
      // lowest bit of this digit crosses into the digit below
      assign hb[g] = q[g*3];
      assign load_msb[g] = i_bcd_load[g*4+3];
      // bit-0 adder: q1 + c0 + crossing bit, carry saved in c0
      assign next_q[g*3] = q[g*3+1] ^ c0[g] ^ hb[g+1];
      assign next_c0[g] = (q[g*3+1] & c0[g]) | (q[g*3+1] & hb[g+1])
                          | (c0[g] & hb[g+1]);
      assign next_q[g*3+1] = q[g*3+2];
      // bit-2 adder: saved top bit + crossing bit, carry saved in c2
      assign next_q[g*3+2] = c2[g] ^ hb[g+1];
      assign next_c2[g] = c2[g] & hb[g+1];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
         c0 <= '0;
         c2 <= '0;
      end else if (!i_parallel_load_n) begin
         for (int g = 0; g < DIGITS; g++) begin
            q[g*3 +: 3] <= i_bcd_load[g*4 +: 3];
         end
         c2 <= load_msb;
         c0 <= '0;
      end else if (dstate == sbc_pkg::SBC_D_RUN) begin
         q <= next_q;
         c0 <= next_c0;
         c2 <= next_c2;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         dstate <= sbc_pkg::SBC_D_IDLE;
         d_cnt <= '0;
         o_ser_bit <= 1'b0;
         o_ser_valid <= 1'b0;
         o_conv_done <= 1'b0;
         o_d2b_busy <= 1'b0;
      end else if (!i_parallel_load_n) begin
         dstate <= sbc_pkg::SBC_D_RUN;
         d_cnt <= '0;
         o_ser_valid <= 1'b0;
         o_conv_done <= 1'b0;
         o_d2b_busy <= 1'b1;
      end else begin
         o_ser_valid <= 1'b0;
         o_conv_done <= 1'b0;
         unique case (dstate)
            sbc_pkg::SBC_D_IDLE: o_d2b_busy <= 1'b0;
            sbc_pkg::SBC_D_RUN: begin
               o_ser_bit <= q[0];
               o_ser_valid <= 1'b1;
               d_cnt <= d_cnt + `SBC_CNT_ONE;
               if (d_cnt == D_LAST) begin
                  dstate <= sbc_pkg::SBC_D_IDLE;
                  o_conv_done <= 1'b1;
                  o_d2b_busy <= 1'b0;
               end
            end
         endcase
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic [4:0] dv0;
   logic [CW-1:0] ser_cnt;
   assign dv0 = {1'b0, c2[0], 3'h0} + {3'h0, c0[0], 1'b0} + {2'h0, q[2:0]};

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_parallel_load_n) begin
         ser_cnt <= '0;
      end else if (o_ser_valid) begin
         ser_cnt <= ser_cnt + `SBC_CNT_ONE;
      end
   end

   sequence s_start;
      b_take && !i_start_n;
   endsequence

   sequence s_shift;
      b_take && i_start_n && bstate == sbc_pkg::SBC_B_SHIFT;
   endsequence

   sequence s_run;
      i_parallel_load_n && dstate == sbc_pkg::SBC_D_RUN;
   endsequence

   AST_MSB_FIRST: assert property (s_start |=> b_cnt == `SBC_CNT_ONE)
      else $error("first bit does not restart the count");
   AST_DOUBLE: assert property (s_shift |=> bcd_sh[0] == $past(i_bin_bit)
      && ($past(bcd_sh[3:0]) >= 4'h5 || bcd_sh[3:1] == $past(bcd_sh[2:0])))
      else $error("shift did not double and take the bit");
   AST_DIGIT_FIX: assert property ((s_shift and bcd_sh[3:0] >= 4'h5)
      |=> bcd_sh[4] == (BW > 4) && bcd_sh[3:1] == $past(bcd_sh[2:0]) - 3'h5)
      else $error("digit of five or more not corrected");
   AST_RESULT: assert property (bstate == sbc_pkg::SBC_B_PUSH && buf_ready && !o_bcd_valid
      |=> o_bcd_valid && o_bcd == $past(bcd_sh))
      else $error("bcd result not presented");
   AST_START_CLEAR: assert property (s_start
      |=> bcd_sh == {{(BW-1){1'b0}}, $past(i_bin_bit)})
      else $error("start did not clear the register");
   AST_SER_OUT: assert property (s_run |=> o_ser_valid && o_ser_bit == $past(q[0]))
      else $error("serial bit not taken from the lowest bit");
   AST_ADD5: assert property (s_run
      |=> dv0 == ($past(dv0) >> 1) + ($past(hb[1]) ? `SBC_FIVE : 5'h00))
      else $error("halving lost the crossing weight of five");
   AST_CSA: assert property (s_run ##1 s_run |-> dv0 <= 5'h09)
      else $error("carry-save digit above nine");
   AST_DONE: assert property (o_conv_done |-> ser_cnt == D_LAST && o_ser_valid)
      else $error("done before every output bit");
   AST_LOAD: assert property (!i_parallel_load_n
      |=> c0 == '0 && c2 == $past(load_msb) && dstate == sbc_pkg::SBC_D_RUN)
      else $error("load did not set the carries");
   AST_STEP: assert property (s_run |=> d_cnt == $past(d_cnt) + `SBC_CNT_ONE)
      else $error("more or less than one bit per clock");

endmodule

`default_nettype wire

// ===== tb/sbc_user_model.sv
// Purpose: user logic that feeds serial binary words and reads bcd words
// Assumes: shares the converter clock; outputs change by nba after a rising edge
// Notes: slow mode spaces the bits and throttles the reader; hold stops the reader
`timescale 1ns/1ps
`default_nettype none

module sbc_user_model #(
   parameter int BIN_W = 16
) (
   // clock
   input wire logic i_clk,
   // pacing
   input wire logic i_slow,
   input wire logic i_hold,
   // serial binary side
   input wire logic i_bin_ready,
   output logic o_bin_bit,
   output logic o_bin_valid,
   output logic o_start_n,
   // bcd reader side
   output logic o_bcd_ready
);
   logic [1:0] tick = 2'h0;

   initial begin
      o_bin_bit = 1'b0;
      o_bin_valid = 1'b0;
      o_start_n = 1'b1;
      o_bcd_ready = 1'b0;
   end

   always @(posedge i_clk) begin
      tick <= tick + 2'h1;
      o_bcd_ready <= !i_hold && (!i_slow || tick == 2'h3);
   end

   // first nb bits of v; each held until taken
   task automatic send_bits(input logic [BIN_W-1:0] v, input int nb, output logic to);
      int n;
      int k;
      to = 1'b0;
      for (n = 0; n < nb; n++) begin
         o_bin_valid <= 1'b1;
         o_start_n <= (n != 0);
         o_bin_bit <= v[BIN_W-1-n];
         k = 0;
         do begin
            @(posedge i_clk);
            k++;
         end while (i_bin_ready !== 1'b1 && k < 300);
         if (k >= 300) to = 1'b1;
         if (i_slow) begin
            o_bin_valid <= 1'b0;
            o_bin_bit <= ~v[BIN_W-1-n];
            @(posedge i_clk);
         end
      end
      o_bin_valid <= 1'b0;
      o_start_n <= 1'b1;
      o_bin_bit <= ~o_bin_bit;
      @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ===== tb/tb_sbc_conv.sv
// Purpose: self-checking bench of the serial code converter
// Assumes: default widths; one 10 MHz clock
// Notes: drivers queue expected words, monitors on the outputs check them
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end

module tb_sbc_conv;
   localparam int DIGITS = 5;
   localparam int BIN_W = 16;
   localparam int DEC_BITS = 17;
   localparam int BW = 4 * DIGITS;
   logic i_clk, i_rst, bin_bit, bin_valid, start_n, bin_ready, bcd_valid, bcd_ready;
   logic load_n, ser_bit, ser_valid, conv_done, busy, to;
   logic slow = 1'b0;
   logic hold = 1'b0;
   logic [BW-1:0] bcd, bcd_load, e_bcd;
   logic [DEC_BITS-1:0] ser_word, e_bin;
   logic [BW-1:0] exp_bcd[$];
   logic [DEC_BITS-1:0] exp_bin[$];
   int err_total = 0;
   int cmp_count = 0;
   int seed = 32'h159dc9ff;
   int ser_n = 0;
   int bvals[8] = '{0, 1, 5, 9, 10, 49999, 59999, 65535};
   int dvals[8] = '{0, 5, 9, 50, 12345, 55555, 80000, 99999};

   sbc_conv #(.DIGITS(DIGITS), .BIN_W(BIN_W), .DEC_BITS(DEC_BITS)) sbc_conv_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_bin_bit(bin_bit), .i_bin_valid(bin_valid),
      .i_start_n(start_n), .o_bin_ready(bin_ready), .o_bcd(bcd), .o_bcd_valid(bcd_valid),
      .i_bcd_ready(bcd_ready), .i_bcd_load(bcd_load), .i_parallel_load_n(load_n),
      .o_ser_bit(ser_bit), .o_ser_valid(ser_valid), .o_conv_done(conv_done),
      .o_d2b_busy(busy));
   sbc_user_model #(.BIN_W(BIN_W)) sbc_user_model_i (
      .i_clk(i_clk), .i_slow(slow), .i_hold(hold), .i_bin_ready(bin_ready),
      .o_bin_bit(bin_bit), .o_bin_valid(bin_valid), .o_start_n(start_n),
      .o_bcd_ready(bcd_ready));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   function automatic logic [BW-1:0] to_bcd(input int v);
      logic [BW-1:0] r;
      int i;
      r = '0;
      for (i = 0; i < DIGITS; i++) begin
         r[i*4 +: 4] = 4'(v % 10);
         v = v / 10;
      end
      return r;
   endfunction

   task automatic test_done;
      if (exp_bcd.size() != 0 || exp_bin.size() != 0) err_total++;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic b2d(input int v);
      exp_bcd.push_back(to_bcd(v));
      sbc_user_model_i.send_bits(16'(v), BIN_W, to);
      `CHK("bin_taken", 1'b0, to)
   endtask

   // gap above zero: cut short by the next load
   task automatic d2b(input int v, input int gap);
      int k;
      bcd_load <= to_bcd(v);
      load_n <= 1'b0;
      @(posedge i_clk);
      load_n <= 1'b1;
      bcd_load <= ~to_bcd(v);
      if (gap > 0) begin
         repeat (gap) @(posedge i_clk);
         return;
      end
      exp_bin.push_back(DEC_BITS'(v));
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (conv_done !== 1'b1 && k < 40);
      `CHK("done_cycles", DEC_BITS + 1, k)
      @(posedge i_clk);
   endtask

   task automatic drain;
      int k;
      for (k = 0; k < 400 && (exp_bcd.size() + exp_bin.size()) != 0; k++) @(posedge i_clk);
   endtask

   always @(posedge i_clk) begin
      if (bcd_valid === 1'b1 && bcd_ready === 1'b1) begin
         e_bcd = (exp_bcd.size() != 0) ? exp_bcd.pop_front() : 'x;
         `CHK("bcd", e_bcd, bcd)
      end
      if (load_n === 1'b0) begin
         ser_n = 0;
      end else if (ser_valid === 1'b1) begin
         if (ser_n < DEC_BITS) ser_word[ser_n] = ser_bit;
         ser_n++;
         `CHK("busy", !conv_done, busy)
         if (conv_done === 1'b1) begin
            `CHK("ser_count", DEC_BITS, ser_n)
            e_bin = (exp_bin.size() != 0) ? exp_bin.pop_front() : 'x;
            `CHK("ser_word", e_bin, ser_word)
            ser_n = 0;
         end
      end
   end

   initial begin
      repeat (100000) @(posedge i_clk);
      err_total++;
      test_done();
   end

   initial begin
      i_rst = 1'b1;
      load_n = 1'b1;
      bcd_load = '0;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      `CHK("rst_valid", 1'b0, bcd_valid)
      foreach (bvals[i]) b2d(bvals[i]);
      repeat (8) b2d($random(seed) & 32'hFFFF);
      sbc_user_model_i.send_bits(16'hFFFF, 5, to);
      b2d(4321);
      drain();
      $display("test binary to bcd done");
      slow <= 1'b1;
      hold <= 1'b1;
      repeat (3) b2d($random(seed) & 32'hFFFF);
      repeat (6) @(posedge i_clk);
      `CHK("bin_ready_full", 1'b0, bin_ready)
      hold <= 1'b0;
      b2d(99);
      drain();
      slow <= 1'b0;
      $display("test reader stall done");
      foreach (dvals[i]) d2b(dvals[i], 0);
      repeat (6) d2b(($random(seed) & 32'h7FFFFFFF) % 100000, 0);
      d2b(77777, 6);
      d2b(31415, 0);
      drain();
      $display("test bcd to binary done");
      test_done();
   end
endmodule
`default_nettype wire
